// ### key_switch_model.sv
// Behavioural model of the keys and the halt switch wired to the wake pins.
`timescale 1ns/10ps
`default_nettype none
module key_switch_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic i_halt_cmd,
  input wire logic [3:0] i_wake_cmd,
  output logic o_halt,
  output logic [3:0] o_wake
);
  logic [14:0] line = 15'h3DEF;
  logic [4:0] now;
  // A slow switch settles three cycles after it is moved.
  always @(posedge i_clock) begin
    line <= {line[9:0], i_halt_cmd, i_wake_cmd};
  end
  assign now = i_slow ? line[14:10] : {i_halt_cmd, i_wake_cmd};
  // Keys pull to ground, and the halt switch stays low while any key is pressed.
  assign o_halt = now[4] & (&now[3:0]);
  // Keys only ever give logic levels, so no wake pin carries an analog voltage.
  assign o_wake = now[3:0];
endmodule : key_switch_model
`default_nettype wire

// ### key_wakeup.sv
// Key wakeup release logic with AXI4-Lite register access and sleep controller.
//
// Summary of operation
// - Halt pin and four wake inputs end sleep.
// - One enable bit per wake input.
// - Sleep entered by register, left on low wake input or high halt pin.
// - Pending release at entry starts warm-up immediately.
// - Halt pin always releases, no enable.
// - Level mode high/low; edge mode rising, inputs unused.
`timescale 1ns/10ps
`default_nettype none
module key_wakeup (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [key_wakeup_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [key_wakeup_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_halt_release,
  input wire logic i_wake_input_a,
  input wire logic i_wake_input_b,
  input wire logic i_wake_input_c,
  input wire logic i_wake_input_d,
  output logic o_sleeping,
  output logic o_warmup,
  output logic o_release_request
);
  import key_wakeup_pkg::*;

  logic [3:0] wake_en;
  logic level_mode;
  sleep_state_e state;
  logic [7:0] warm_count;
  logic halt_prev;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;

  key_wakeup_sync_if pins_if ();
  assign pins_if.raw = {i_wake_input_d, i_wake_input_c, i_wake_input_b, i_wake_input_a,
                        i_halt_release};
  key_wakeup_pin_sync u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .pins(pins_if)
  );

  wire logic halt_level = pins_if.level[0];
  wire logic [3:0] wake_level = pins_if.level[4:1];
  wire logic wake_low_any = |(wake_en & ~wake_level);
  wire logic halt_rise = halt_level & ~halt_prev;
  // Level mode: halt high or enabled input low; edge mode: halt rising only.
  wire logic halt_cond = level_mode ? halt_level : halt_rise;
  wire logic wake_cond = level_mode & wake_low_any;
  wire logic release_req = halt_cond | wake_cond;

  // Write channel: address and data taken in either order, answered after both.
  wire logic do_write = aw_held & w_held & ~o_bvalid;
  wire logic hit_en = (aw_addr == ADDR_WAKE_PIN_ENABLE);
  wire logic hit_sco = (aw_addr == ADDR_SYSTEM_CONTROL_ONE);
  wire logic sleep_cmd = do_write & hit_sco & w_lane0 & w_data[SCO_SLEEP_BIT];
  wire logic rd_en = (i_araddr == ADDR_WAKE_PIN_ENABLE);
  wire logic rd_sco = (i_araddr == ADDR_SYSTEM_CONTROL_ONE);
  wire logic rd_stat = (i_araddr == ADDR_WAKE_STATUS);
  wire logic rd_hit = rd_en | rd_sco | rd_stat;
  // Wake enable is write only and reads as zero.
  wire logic [31:0] rd_value = rd_sco ? {30'h0, level_mode, 1'b0} :
                               rd_stat ? {24'h0, wake_level, halt_level,
                                          release_req, o_warmup, o_sleeping} : 32'h0;

  assign o_awready = ~aw_held;
  assign o_wready = ~w_held;
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
    end else begin
      if (i_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (i_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_lane0 <= i_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= (hit_en || hit_sco) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      wake_en <= WAKE_EN_RESET;
      level_mode <= LEVEL_MODE_RESET;
    end else if (do_write && w_lane0) begin
      if (hit_en) begin
        wake_en <= w_data[WAKE_EN_LSB +: 4];
      end
      if (hit_sco) begin
        level_mode <= w_data[SCO_LEVEL_MODE_BIT];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && !o_rvalid) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_value;
      o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Sleep controller with warm-up count after each release.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state <= ST_RUN;
      warm_count <= 8'h00;
      halt_prev <= 1'b0;
      o_release_request <= 1'b0;
    end else begin
      halt_prev <= halt_level;
      o_release_request <= release_req;
      case (state)
        ST_RUN: begin
          if (sleep_cmd) begin
            // A release already pending skips sleep and warms up at once.
            state <= release_req ? ST_WARMUP : ST_SLEEP;
            warm_count <= 8'(WARMUP_CYCLES - 1);
          end
        end
        ST_SLEEP: begin
          if (release_req) begin
            state <= ST_WARMUP;
            warm_count <= 8'(WARMUP_CYCLES - 1);
          end
        end
        ST_WARMUP: begin
          if (warm_count == 8'h00) begin
            state <= ST_RUN;
          end else begin
            warm_count <= warm_count - 8'h01;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end
  assign o_sleeping = (state == ST_SLEEP);
  assign o_warmup = (state == ST_WARMUP);

  chk_pending_skips_sleep: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state == ST_RUN && sleep_cmd && release_req) |=> o_warmup)
    else $error("sleep entered with release pending");
  chk_wake_low_release: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_sleeping && level_mode && wake_low_any) |=> o_warmup)
    else $error("enabled low wake input did not release");
  chk_disabled_ignored: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_sleeping && wake_en == 4'h0 && !halt_level && !halt_prev) |=> !o_warmup)
    else $error("disabled wake inputs released sleep");
  chk_halt_high_level: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_sleeping && level_mode && halt_level) |=> o_warmup)
    else $error("halt pin high did not release");
  chk_edge_mode_inputs: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_sleeping && !level_mode && !halt_level) |=> o_sleeping)
    else $error("edge mode released without rising halt pin");
  chk_request_or: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (halt_cond || wake_cond) |=> o_release_request)
    else $error("release request missing");
  chk_warmup_length: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(o_warmup) |-> o_warmup [*8])
    else $error("warm-up ended early");
  chk_warmup_ends: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(o_warmup) |-> ##[1:60] !o_warmup)
    else $error("warm-up did not end");
  cov_sleep_release: cover property (@(posedge i_clock) disable iff (!i_resetn)
    o_sleeping ##1 o_warmup);
  cov_immediate_warmup: cover property (@(posedge i_clock) disable iff (!i_resetn)
    (state == ST_RUN && sleep_cmd && release_req));
  cov_edge_release: cover property (@(posedge i_clock) disable iff (!i_resetn)
    (o_sleeping && !level_mode && halt_rise));
endmodule : key_wakeup
`default_nettype wire

// ### key_wakeup_release_tb.sv
// Self-checking testbench of the key wakeup block.
`timescale 1ns/10ps
`default_nettype none
module key_wakeup_release_tb;
  import key_wakeup_pkg::*;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h5C, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic halt_cmd = 1'b0, slow = 1'b0;
  logic [3:0] wake_cmd = 4'hF, wake;
  logic halt, awready, wready, bvalid, arready, rvalid, sleeping, warmup, relreq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  int n_fail = 0, n_tests = 0, n;
  always #20 i_clock = ~i_clock;
  key_switch_model u_keys (.i_clock(i_clock), .i_slow(slow), .i_halt_cmd(halt_cmd),
    .i_wake_cmd(wake_cmd), .o_halt(halt), .o_wake(wake));
  key_wakeup u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_halt_release(halt), .i_wake_input_a(wake[0]), .i_wake_input_b(wake[1]),
    .i_wake_input_c(wake[2]), .i_wake_input_d(wake[3]), .o_sleeping(sleeping),
    .o_warmup(warmup), .o_release_request(relreq));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Status word expected from the pin levels seen by the bench and the model state.
  function automatic logic [31:0] stat(input logic slp, input logic rq);
    return {24'h0, wake, halt, rq, 1'b0, slp};
  endfunction : stat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
  endtask : cyc
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int k = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clock);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    r = bresp;
    if (bvalid !== 1'b1) n_fail++;
    bready <= 1'b0;
    @(posedge i_clock);
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clock);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    d = rdata;
    r = rresp;
    if (rvalid !== 1'b1) n_fail++;
    rready <= 1'b0;
    @(posedge i_clock);
  endtask : axr
  task automatic waitw();
    n = 0;
    while (warmup !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      n++;
    end
    chk(warmup, 1);
  endtask : waitw
  task automatic conclude();
    $display("counts: tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    cyc(2);
    i_resetn <= 1'b1;
    cyc(4);
    axw(ADDR_WAKE_PIN_ENABLE, 32'hF0);
    chk(r, RESP_OKAY);
    axr(ADDR_WAKE_PIN_ENABLE);
    chk(d, 32'h0);
    axr(8'h00);
    chk(r, RESP_SLVERR);
    axw(8'h04, 32'hFF);
    chk(r, RESP_SLVERR);
    axr(ADDR_WAKE_STATUS);
    chk(d, stat(1'b0, 1'b0));
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      axw(ADDR_WAKE_PIN_ENABLE, 32'h10 << i);
      d = xs();
      wake_cmd <= d[3:0] | (4'h1 << i);
      slow <= d[4];
      axw(ADDR_SYSTEM_CONTROL_ONE, 32'h3);
      cyc(10);
      axr(ADDR_WAKE_STATUS);
      chk(d, stat(1'b1, 1'b0));
      chk(relreq, 1'b0);
      wake_cmd <= 4'h0;
      waitw();
      n = 0;
      while (warmup === 1'b1 && n < 200) begin
        @(posedge i_clock);
        n++;
      end
      chk(n, WARMUP_CYCLES);
      chk(sleeping, 1'b0);
      wake_cmd <= 4'hF;
      cyc(10);
    end
    $display("test 2 done");
    axw(ADDR_WAKE_PIN_ENABLE, 32'h00);
    axw(ADDR_SYSTEM_CONTROL_ONE, 32'h0);
    wake_cmd <= 4'h0;
    cyc(10);
    axw(ADDR_SYSTEM_CONTROL_ONE, 32'h1);
    cyc(10);
    chk(sleeping, 1'b1);
    wake_cmd <= 4'hF;
    cyc(10);
    chk(sleeping, 1'b1);
    halt_cmd <= 1'b1;
    waitw();
    $display("test 3 done");
    cyc(60);
    axw(ADDR_SYSTEM_CONTROL_ONE, 32'h2);
    cyc(10);
    axw(ADDR_SYSTEM_CONTROL_ONE, 32'h3);
    waitw();
    chk(relreq, 1'b1);
    chk(sleeping, 1'b0);
    $display("test 4 done");
    cyc(60);
    halt_cmd <= 1'b0;
    conclude();
  end
  initial begin
    cyc(5000);
    n_fail++;
    conclude();
  end
endmodule : key_wakeup_release_tb
`default_nettype wire

// ### kwu_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module key_wakeup_pin_sync (
  input wire logic i_clock,
  input wire logic i_resetn,
  key_wakeup_sync_if.sync pins
);
  logic [4:0] stage1;
  logic [4:0] stage2;
  logic [4:0] stage3;
  logic [4:0] held;
  wire logic [4:0] agree = ~(stage2 ^ stage3);
  wire logic [4:0] next_held = (agree & stage3) | (~agree & held);

  // Reset value matches idle pins: wake inputs high, halt pin low.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      stage1 <= 5'h1E;
      stage2 <= 5'h1E;
      stage3 <= 5'h1E;
      held <= 5'h1E;
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      held <= next_held;
    end
  end
  assign pins.level = held;
endmodule : key_wakeup_pin_sync
`default_nettype wire

// ### kwu_pkg.sv
// Package with register map, field positions and timing constants of the key wakeup block.
package key_wakeup_pkg;
  localparam int ADDR_W = 8;
  // Printed offset 0x31 is not a multiple of four, so it is an index.
  localparam logic [7:0] IDX_WAKE_PIN_ENABLE = 8'h31;
  localparam logic [7:0] IDX_SYSTEM_CONTROL_ONE = 8'h38;
  localparam logic [7:0] IDX_WAKE_STATUS = 8'h39;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_PIN_ENABLE = 8'(IDX_WAKE_PIN_ENABLE * 4);
  localparam logic [ADDR_W-1:0] ADDR_SYSTEM_CONTROL_ONE = 8'(IDX_SYSTEM_CONTROL_ONE * 4);
  localparam logic [ADDR_W-1:0] ADDR_WAKE_STATUS = 8'(IDX_WAKE_STATUS * 4);
  // Wake pin enable field: bits 7..4 for inputs d..a.
  localparam int WAKE_EN_LSB = 4;
  localparam logic [3:0] WAKE_EN_RESET = 4'h0;
  // System control one: bit 0 requests sleep, bit 1 selects level release.
  localparam int SCO_SLEEP_BIT = 0;
  localparam int SCO_LEVEL_MODE_BIT = 1;
  localparam logic LEVEL_MODE_RESET = 1'b0;
  // Warm-up time in ns and its cycle count at the 40 ns clock.
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int WARMUP_NS = 2000;
  localparam int WARMUP_CYCLES = (WARMUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_RUN = 2'h0, ST_SLEEP = 2'h1, ST_WARMUP = 2'h3} sleep_state_e;
endpackage : key_wakeup_pkg

// ### kwu_sync_if.sv
// Interface carrying raw pins into the synchroniser and filtered levels out.
`timescale 1ns/10ps
`default_nettype none
interface key_wakeup_sync_if;
  logic [4:0] raw;
  logic [4:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : key_wakeup_sync_if
`default_nettype wire
